// *** cpx_exec.sv ***
// execution unit for compare memory byte with working register, skip if
// greater; assumes the fetch stage presents the next word with a valid
// flag and that the data memory returns read data within phase two
`timescale 1ns/10ps

// Notes on behaviour
// - unsigned compare of byte with working register; no result, flags untouched.
// - byte greater than working register squashes fetched word, runs a no-op.
// - opcode is 0110010a in upper byte, file address in lower byte.
// - access bit zero picks access bank, one picks bank select register.
// - access zero, extended set on, address up to 95 uses indexed offset.
// - one cycle without skip, two with skip, three over two-word.
// - skipping a two-word instruction adds two full no-operation cycles.
// - phase one decode, two read, three compare, four writes nothing.
module cpx_exec (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // instruction words
    input  wire logic [15:0]          instr_i,
    input  wire cpx_pkg::fetch_type   next_i,
    // core state
    input  wire logic [7:0]           working_register_alias_i,
    input  wire logic [3:0]           bank_select_register_i,
    input  wire logic                 ext_set_en_i,
    input  wire logic [11:0]          index_base_i,
    // data memory
    input  wire logic [7:0]           mem_rdata_i,
    output logic [11:0]               mem_addr_o,
    output logic                      mem_rd_o,
    output logic                      mem_wr_o,
    // control toward the core
    output logic [1:0]                phase_o,
    output logic                      squash_o,
    output logic                      pc_inc_o,
    output logic                      flags_we_o,
    output logic                      busy_o,
    output logic [1:0]                cycles_o
);

    cpx_pkg::unit_type s_ff;
    cpx_pkg::unit_type nxt_s;
    logic [11:0]       op_addr;
    logic              hit;
    logic              two_word;
    logic [8:0]        diff;

    // ****************************************************************
    // operand address
    // ****************************************************************
    cpx_addr u_addr (
        .acc_i                  (instr_i[8]),
        .faddr_i                (instr_i[7:0]),
        .bank_select_register_i (bank_select_register_i),
        .ext_set_en_i           (ext_set_en_i),
        .index_base_i           (index_base_i),
        .addr_o                 (op_addr)
    );

    // decode and compare terms
    assign hit      = (instr_i[15:9] == cpx_pkg::OPC_HI7);
    // subtraction with borrow: no borrow and nonzero means byte is greater
    assign diff     = {1'b0, mem_rdata_i} - {1'b0, working_register_alias_i};
    // two-word instructions carry 1111 in their second word; first words
    // use 1100, 1110 11xx and 1110 1111 style prefixes
    assign two_word = next_i.valid && ((next_i.word[15:12] == 4'hC) ||
                      (next_i.word[15:9] == 7'h76) ||
                      (next_i.word[15:8] == 8'hEE) ||
                      (next_i.word[15:8] == 8'hEF) ||
                      (next_i.word[15:8] == 8'hEC));

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_s        = s_ff;
        nxt_s.rd     = 1'b0;
        nxt_s.squash = 1'b0;
        nxt_s.pc_inc = 1'b0;
        nxt_s.phase  = s_ff.phase + 2'h1;
        unique case (s_ff.st)
            cpx_pkg::ST_EXEC: begin
                unique case (s_ff.phase)
                    2'h0: begin
                        // decode phase latches operand fields
                        nxt_s.is_cmp = hit;
                        nxt_s.acc    = instr_i[8];
                        nxt_s.faddr  = instr_i[7:0];
                        nxt_s.addr   = op_addr;
                        nxt_s.rd     = hit;
                        nxt_s.cyc_cnt = 2'h1;
                    end
                    2'h1: begin
                        // compare needs the read byte, so it waits for q3
                        nxt_s.cmp_gt = s_ff.is_cmp && !diff[8] &&
                                       (diff[7:0] != 8'h00);
                    end
                    2'h2: begin
                        // q4 writes nothing; pc moves on at cycle end
                        nxt_s.pc_inc = 1'b1;
                    end
                    2'h3: begin
                        if (s_ff.is_cmp && s_ff.cmp_gt) begin
                            nxt_s.st      = cpx_pkg::ST_SKIP1;
                            nxt_s.squash  = 1'b1;
                            nxt_s.cyc_cnt = 2'h2;
                        end
                        nxt_s.is_cmp = 1'b0;
                        nxt_s.cmp_gt = 1'b0;
                    end
                endcase
            end
            cpx_pkg::ST_SKIP1: begin
                nxt_s.squash = 1'b1;
                if (s_ff.phase == cpx_pkg::PHASE_LAST) begin
                    nxt_s.squash = 1'b0;
                    if (two_word) begin
                        nxt_s.st      = cpx_pkg::ST_SKIP2;
                        nxt_s.squash  = 1'b1;
                        nxt_s.cyc_cnt = 2'h3;
                    end else begin
                        nxt_s.st = cpx_pkg::ST_EXEC;
                    end
                end
                if (s_ff.phase == 2'h2) begin
                    nxt_s.pc_inc = 1'b1;
                end
            end
            cpx_pkg::ST_SKIP2: begin
                nxt_s.squash = 1'b1;
                if (s_ff.phase == 2'h2) begin
                    nxt_s.pc_inc = 1'b1;
                end
                if (s_ff.phase == cpx_pkg::PHASE_LAST) begin
                    nxt_s.st     = cpx_pkg::ST_EXEC;
                    nxt_s.squash = 1'b0;
                end
            end
            default: begin
                nxt_s.st = cpx_pkg::ST_EXEC;
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff       <= '0;
            s_ff.st    <= cpx_pkg::ST_EXEC;
            s_ff.phase <= cpx_pkg::PHASE_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs; this unit never writes memory or status flags
    assign mem_addr_o = s_ff.addr;
    assign mem_rd_o   = s_ff.rd;
    assign mem_wr_o   = 1'b0;
    assign flags_we_o = 1'b0;
    assign phase_o    = s_ff.phase;
    assign squash_o   = s_ff.squash;
    assign pc_inc_o   = s_ff.pc_inc;
    assign busy_o     = (s_ff.st != cpx_pkg::ST_EXEC);
    assign cycles_o   = s_ff.cyc_cnt;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_read_in_q2: assert property (
        @(posedge clk_i) disable iff (rst_i)
        mem_rd_o |-> phase_o == 2'h1)
        else $error("operand read outside phase two");
    a_no_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !mem_wr_o && !flags_we_o)
        else $error("compare wrote memory or flags");
    a_skip_on_gt: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_EXEC && phase_o == 2'h3 && s_ff.is_cmp &&
         s_ff.cmp_gt) |=> squash_o [*4])
        else $error("greater byte did not squash a full cycle");
    a_no_skip_le: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_EXEC && phase_o == 2'h3 &&
         !s_ff.cmp_gt) |=> !squash_o && !busy_o)
        else $error("skip without greater byte");
    a_two_word: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_SKIP1 && phase_o == 2'h3 && two_word)
        |=> squash_o [*4])
        else $error("second no-op cycle missing");
    a_cycle_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_SKIP2) |-> cycles_o == 2'h3)
        else $error("two-word skip not counted as three cycles");
    a_skip_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_SKIP1) |-> cycles_o != 2'h1)
        else $error("skip counted as a single cycle");
    a_plain_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_EXEC && phase_o != 2'h0)
        |-> cycles_o == 2'h1)
        else $error("plain cycle not counted as one");
    a_decode_hit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_EXEC && phase_o == 2'h0 &&
         instr_i[15:9] == cpx_pkg::OPC_HI7) |=> mem_rd_o)
        else $error("opcode not decoded");
    a_bank_sel: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_EXEC && phase_o == 2'h0 && instr_i[8])
        |=> mem_addr_o[11:8] == $past(bank_select_register_i))
        else $error("bank select not applied");
    // pc moves exactly once per instruction cycle, in its last phase
    a_pc_adv: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pc_inc_o == (phase_o == cpx_pkg::PHASE_LAST))
        else $error("pc advance not in phase four");
    a_indexed: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_ff.st == cpx_pkg::ST_EXEC && phase_o == 2'h0 && !instr_i[8] &&
         ext_set_en_i && instr_i[7:0] <= cpx_pkg::ILO_LIMIT) |=>
        mem_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
        else $error("indexed offset address wrong");

endmodule : cpx_exec

// *** cpx_pkg.sv ***
// package for the compare-skip-if-greater execution unit
// assumes a four-phase instruction cycle driven by the core clock
package cpx_pkg;

    // ****************************************************************
    // encoding and addressing constants
    // ****************************************************************
    localparam logic [6:0] OPC_HI7        = 7'h32;  // 0110010 then access bit
    localparam logic [7:0] ILO_LIMIT      = 8'h5F;  // indexed window top, 95
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;   // access bank low half
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;   // access bank upper half
    localparam logic [7:0] ACCESS_SPLIT   = 8'h60;  // low/high split of bank
    localparam logic [1:0] PHASE_RESET    = 2'h0;
    localparam logic [1:0] PHASE_LAST     = 2'h3;

    // ****************************************************************
    // state of the execution unit
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_EXEC  = 3'b001,
        ST_SKIP1 = 3'b010,
        ST_SKIP2 = 3'b100
    } exec_state_type;

    typedef struct packed {
        exec_state_type st;
        logic [1:0]     phase;       // q1..q4 as 0..3
        logic           cmp_gt;      // result of phase three compare
        logic           is_cmp;      // instruction in flight is ours
        logic           acc;
        logic [7:0]     faddr;
        logic [11:0]    addr;        // operand address driven out
        logic           rd;          // read strobe, phase two
        logic           squash;      // fetched word discarded
        logic           pc_inc;      // advance pc this cycle end
        logic [1:0]     cyc_cnt;     // instruction cycles used
    } unit_type;

    typedef struct packed {
        logic [15:0] word;
        logic        valid;
    } fetch_type;

endpackage : cpx_pkg

// *** cpx_addr.sv ***
// operand address generator for byte-oriented instructions
// assumes the caller holds its inputs stable through the decode phase
`timescale 1ns/10ps
module cpx_addr (
    // instruction fields
    input  wire logic        acc_i,
    input  wire logic [7:0]  faddr_i,
    // core state
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [11:0] index_base_i,
    // result
    output logic [11:0]      addr_o
);

    // ****************************************************************
    // bank or indexed literal offset selection
    // ****************************************************************
    always_comb begin
        if (acc_i && 1'b1) begin
            addr_o = {bank_select_register_i, faddr_i};
        end else if (ext_set_en_i && (faddr_i <= cpx_pkg::ILO_LIMIT)) begin
            addr_o = index_base_i + {4'h0, faddr_i};
        end else if (faddr_i < cpx_pkg::ACCESS_SPLIT) begin
            addr_o = {cpx_pkg::ACCESS_LO_BANK, faddr_i};
        end else begin
            addr_o = {cpx_pkg::ACCESS_HI_BANK, faddr_i};
        end
    end

endmodule : cpx_addr

// *** tb_cpx_exec.sv ***
// self-checking bench for the compare-skip-if-greater execution unit
// assumes cpx_exec runs one phase per clock and reports it on phase_o
`timescale 1ns/10ps
module tb;
    // ****************************************************************
    // signals and counters
    // ****************************************************************
    logic               clk_i;
    logic               rst_i;
    logic [15:0]        instr_i;
    cpx_pkg::fetch_type next_i;
    logic [7:0]         working_register_alias;
    logic [3:0]         bank_select_register;
    logic               ext;
    logic [11:0]        base;
    logic [7:0]         rdata;
    logic [11:0]        addr;
    logic               rd, wr, sqo, pci, fwe, busy;
    logic [1:0]         ph, cyc;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    int                 prev = 0;
    integer             seed = 32'he1ad;

    cpx_exec uut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
        .next_i(next_i), .working_register_alias_i(working_register_alias),
        .bank_select_register_i(bank_select_register), .ext_set_en_i(ext),
        .index_base_i(base), .mem_rdata_i(rdata), .mem_addr_o(addr),
        .mem_rd_o(rd), .mem_wr_o(wr), .phase_o(ph), .squash_o(sqo),
        .pc_inc_o(pci), .flags_we_o(fwe), .busy_o(busy), .cycles_o(cyc));

    // 50 ns period; stimulus changes on the falling edge only
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ****************************************************************
    // compare and report
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // one phase of outputs against the model
    task automatic step(input int p, input logic sq, rde,
                        input logic [11:0] ae);
        chk("phase", 16'(p), 16'(ph));
        chk("read strobe", 16'(rde), 16'(rd));
        if (rde) chk("operand address", 16'(ae), 16'(addr));
        chk("write strobe", 16'h0000, 16'(wr));
        chk("flag write", 16'h0000, 16'(fwe));
        chk("squash", 16'(sq), 16'(sqo));
        chk("busy", 16'(sq), 16'(busy));
        chk("pc advance", 16'(p == 3), 16'(pci));
    endtask : step

    // ****************************************************************
    // model: drive one instruction at the q4 falling edge, follow it
    // ****************************************************************
    task automatic run(input logic [15:0] iw, nw, input logic [7:0] w, m,
                       input logic e);
        logic [11:0] a;
        logic        ours, two;
        int          n;
        instr_i = iw;
        working_register_alias    = w;
        rdata   = m;
        ext     = e;
        bank_select_register     = 4'($random(seed));
        base    = 12'($random(seed));
        ours    = (iw[15:9] == 7'h32);
        if (iw[8]) a = {bank_select_register, iw[7:0]};
        else if (e && iw[7:0] <= 8'h5F) a = base + 12'(iw[7:0]);
        else a = {(iw[7:0] < 8'h60) ? 4'h0 : 4'hF, iw[7:0]};
        // two-word first words: Cxxx and ECxx up to EFxx
        two = (nw[15:12] == 4'hC) ||
              (nw[15:8] inside {8'hEC, 8'hED, 8'hEE, 8'hEF});
        n = (ours && int'(m) > int'(w)) ? (two ? 2 : 1) : 0;
        for (int p = 0; p < 4; p++) begin
            @(negedge clk_i);
            // the unit reads the fetched word up to the last skip edge of
            // the previous instruction, so it may change only after it
            if (p == 0) next_i = '{word: nw, valid: 1'b1};
            // the previous count still stands during q1
            if (p == 0 && prev != 0)
                chk("cycles", 16'(prev), 16'(cyc));
            step(p, 1'b0, ours && p == 1, a);
        end
        for (int k = 0; k < 4 * n; k++) begin
            @(negedge clk_i);
            step(k % 4, 1'b1, 1'b0, 12'h000);
        end
        prev = 1 + n;
    endtask : run

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [15:0] iw, nw;
        int          t;
        rst_i = 1'b1;
        instr_i = 16'h0000;
        next_i = '{word: 16'h0000, valid: 1'b1};
        working_register_alias = 8'h00;
        bank_select_register = 4'h0;
        ext = 1'b0;
        base = 12'h000;
        rdata = 8'h00;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        // find the last phase of the idle cycle before starting
        t = 0;
        while (ph !== 2'h3 && t < 16) begin
            @(negedge clk_i);
            t++;
        end
        if (t >= 16) begin
            mismatches++;
            tally_and_finish();
        end
        // edges of the indexed window, equal values, two-word skips
        run(16'h645F, 16'h0123, 8'h10, 8'h10, 1'b1);
        run(16'h6460, 16'h0123, 8'h10, 8'h11, 1'b1);
        run(16'h65FF, 16'hC123, 8'h00, 8'hFF, 1'b1);
        run(16'h6405, 16'hEF00, 8'hFF, 8'h00, 1'b0);
        run(16'h6480, 16'hEC00, 8'h7F, 8'h80, 1'b0);
        run(16'h64A0, 16'hEE00, 8'h7F, 8'h80, 1'b1);
        run(16'h6005, 16'h0000, 8'h00, 8'hFF, 1'b0);
        run(16'h6605, 16'h0000, 8'h00, 8'hFF, 1'b1);
        run(16'h6505, 16'h0000, 8'h00, 8'h01, 1'b1);
        // random traffic, back to back
        for (int i = 0; i < 60; i++) begin
            iw = 16'($random(seed));
            nw = 16'($random(seed));
            if (i % 3 != 0) iw[15:9] = 7'h32;
            else if (iw[15:9] == 7'h32) iw[9] = 1'b1;
            if (nw[15:9] == 7'h3B) nw[10] = 1'b0;
            run(iw, nw, 8'($random(seed)), 8'($random(seed)),
                1'($random(seed)));
        end
        tally_and_finish();
    end

    // watchdog against a hung run
    initial begin
        #3000000;
        mismatches++;
        tally_and_finish();
    end
endmodule : tb
